// >>> pkg/tsa_pkg.sv
// constants shared by the sixteen-bit timer and its input conditioning
package tsa_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;
    localparam int PRE_W  = 10;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL_A = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CTRL_B = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CNT_L  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CNT_H  = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CMPA_L = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CMPA_H = 4'h5;
    localparam logic [ADDR_W-1:0] REG_CMPB_L = 4'h6;
    localparam logic [ADDR_W-1:0] REG_CMPB_H = 4'h7;
    localparam logic [ADDR_W-1:0] REG_CAP_L  = 4'h8;
    localparam logic [ADDR_W-1:0] REG_CAP_H  = 4'h9;
    localparam logic [ADDR_W-1:0] REG_FLAG   = 4'hA;
    localparam logic [ADDR_W-1:0] REG_MASK   = 4'hB;
    localparam logic [ADDR_W-1:0] REG_POWER  = 4'hC;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRLA_WGM_LSB  = 0;
    localparam int CTRLA_ENB_BIT  = 5;
    localparam int CTRLA_ENA_BIT  = 7;
    localparam int CTRLB_CS_LSB   = 0;
    localparam int CTRLB_WGM_LSB  = 3;
    localparam int CTRLB_SRC_BIT  = 5;
    localparam int CTRLB_EDGE_BIT = 6;
    localparam int CTRLB_NOISE_BIT = 7;
    localparam int FLAG_OVF_BIT   = 0;
    localparam int FLAG_CMPA_BIT  = 1;
    localparam int FLAG_CMPB_BIT  = 2;
    localparam int FLAG_CAP_BIT   = 3;
    localparam int NUM_FLAGS      = 4;
    localparam int POWER_OFF_BIT  = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0]    RST_BYTE  = 8'h00;
    localparam logic [CNT_W-1:0]     RST_WORD  = 16'h0000;
    localparam logic [NUM_FLAGS-1:0] RST_FLAGS = 4'h0;
    localparam logic                 RST_POWER = 1'b0;

    // ------------------------------------------------------------
    // clock source select codes
    // ------------------------------------------------------------
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    localparam logic [PRE_W-1:0] PRE_MASK8    = 10'h007;
    localparam logic [PRE_W-1:0] PRE_MASK64   = 10'h03F;
    localparam logic [PRE_W-1:0] PRE_MASK256  = 10'h0FF;
    localparam logic [PRE_W-1:0] PRE_MASK1024 = 10'h3FF;

    // ------------------------------------------------------------
    // counting modes and ceilings
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_NORMAL   = 4'h0;
    localparam logic [3:0] MODE_PWM8     = 4'h1;
    localparam logic [3:0] MODE_PWM9     = 4'h2;
    localparam logic [3:0] MODE_PWM10    = 4'h3;
    localparam logic [3:0] MODE_CTC_A    = 4'h4;
    localparam logic [3:0] MODE_FAST8    = 4'h5;
    localparam logic [3:0] MODE_FAST9    = 4'h6;
    localparam logic [3:0] MODE_FAST10   = 4'h7;
    localparam logic [3:0] MODE_CTC_CAP  = 4'hC;
    localparam logic [3:0] MODE_FAST_CAP = 4'hE;
    localparam logic [3:0] MODE_FAST_A   = 4'hF;

    localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;
    localparam logic [CNT_W-1:0] TOP_8BIT   = 16'h00FF;
    localparam logic [CNT_W-1:0] TOP_9BIT   = 16'h01FF;
    localparam logic [CNT_W-1:0] TOP_10BIT  = 16'h03FF;

    // consecutive equal samples the capture filter needs
    localparam int NOISE_SAMPLES = 4;

endpackage : tsa_pkg

// >>> verilog/tsa_edge_filter.sv
// pin synchroniser, optional noise filter and edge detector
`timescale 1ns/1ps
`default_nettype none

module tsa_edge_filter
#(
    parameter int SAMPLES = tsa_pkg::NOISE_SAMPLES
)
(
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic pinIn,
    input  wire logic filterOn,
    input  wire logic risingSel,
    output logic      edgeEvt
);
    import tsa_pkg::*;

    logic               sync1_ff;
    logic               sync2_ff;
    logic [SAMPLES-1:0] hist_ff;
    logic               level_ff;
    logic               prev_ff;

    // ------------------------------------------------------------
    // synchroniser: stage one feeds stage two only
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= pinIn;
            sync2_ff <= sync1_ff;
        end
    end

    // ------------------------------------------------------------
    // filter: level moves only after SAMPLES equal samples
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            hist_ff  <= '0;
            level_ff <= 1'b0;
        end
        else
        begin
            hist_ff <= {hist_ff[SAMPLES-2:0], sync2_ff};
            if (!filterOn)
                level_ff <= sync2_ff;
            else if (&hist_ff)
                level_ff <= 1'b1;
            else if (~|hist_ff)
                level_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // edge detect
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_ff <= 1'b0;
            edgeEvt <= 1'b0;
        end
        else
        begin
            prev_ff <= level_ff;
            edgeEvt <= risingSel ? (level_ff & ~prev_ff) : (~level_ff & prev_ff);
        end
    end

endmodule : tsa_edge_filter

`default_nettype wire

// >>> verilog/tsa_timer.sv
// sixteen-bit timer with byte-wide register access through a shared high-byte latch
//
// Operation
// - four interrupt sources, each with own flag
// - sixteen-bit count, compares, capture; byte controls
// - flags in flag register, gated by mask bits
// - count on prescaled or external pin tick
// - compare continuously; match sets flag, drives wave
// - capture count on filtered pin or comparator edge
// - ceiling from fixed values, compare A, capture
// - fast compare A ceiling: no A wave, buffered
// - bottom zero, max all ones, top ceiling
// - one shared high-byte latch per timer
// - low write loads latch and low together
// - count or capture low read copies high byte into latch
// - compare reads bypass the shared latch
// - cpu count write beats clear and count
// - select zero stops count, access stays
// - capture flag set with capture copy
`timescale 1ns/1ps
`default_nettype none

module tsa_timer
(
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    input  wire logic [tsa_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [tsa_pkg::DATA_W-1:0]  regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [tsa_pkg::DATA_W-1:0]  regRdata,
    input  wire logic                        externalCountPin,
    input  wire logic                        capturePin,
    input  wire logic                        comparatorOutput,
    output logic                             waveOutA,
    output logic                             waveOutB,
    output logic                             overflowReq,
    output logic                             compareAReq,
    output logic                             compareBReq,
    output logic                             captureReq
);
    import tsa_pkg::*;

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic isPwm(input logic [3:0] m);
        isPwm = (m == MODE_PWM8) || (m == MODE_PWM9) || (m == MODE_PWM10) ||
                (m == MODE_FAST8) || (m == MODE_FAST9) || (m == MODE_FAST10) ||
                (m == MODE_FAST_CAP) || (m == MODE_FAST_A);
    endfunction : isPwm

    function automatic logic [CNT_W-1:0] topOf(input logic [3:0] m,
                                               input logic [CNT_W-1:0] cmpA,
                                               input logic [CNT_W-1:0] cap);
        unique case (m)
            MODE_PWM8, MODE_FAST8:            topOf = TOP_8BIT;
            MODE_PWM9, MODE_FAST9:            topOf = TOP_9BIT;
            MODE_PWM10, MODE_FAST10:          topOf = TOP_10BIT;
            MODE_CTC_A, MODE_FAST_A:          topOf = cmpA;
            MODE_CTC_CAP, MODE_FAST_CAP:      topOf = cap;
            default:                          topOf = CNT_MAX;
        endcase
    endfunction : topOf

    function automatic logic waveNext(input logic cur, input logic en, input logic pwm,
                                      input logic wrap, input logic match);
        if (!en)
            waveNext = 1'b0;
        else if (pwm)
            waveNext = match ? 1'b0 : (wrap ? 1'b1 : cur);
        else
            waveNext = match ? ~cur : cur;
    endfunction : waveNext

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DATA_W-1:0]    ctrlA_ff;
    logic [DATA_W-1:0]    ctrlB_ff;
    logic [NUM_FLAGS-1:0] mask_ff;
    logic [NUM_FLAGS-1:0] flags_ff;
    logic                 powerOff_ff;
    logic [DATA_W-1:0]    temp_ff;
    logic [CNT_W-1:0]     count_ff;
    logic [CNT_W-1:0]     cmpABuf_ff;
    logic [CNT_W-1:0]     cmpBBuf_ff;
    logic [CNT_W-1:0]     cmpA_ff;
    logic [CNT_W-1:0]     cmpB_ff;
    logic [CNT_W-1:0]     capture_ff;
    logic [PRE_W-1:0]     pre_ff;
    logic                 blockMatch_ff;

    logic [3:0]           mode;
    logic [2:0]           clkSel;
    logic                 pwmMode;
    logic [CNT_W-1:0]     top;
    logic                 atTop;
    logic                 tick;
    logic                 extEdge;
    logic                 capEdge;
    logic                 capIsTop;
    logic                 capEvt;
    logic                 matchA;
    logic                 matchB;
    logic                 wrapEvt;
    logic                 wrCntL;
    logic                 wrCapL;
    logic [NUM_FLAGS-1:0] flagSet;
    logic [NUM_FLAGS-1:0] flagClr;
    logic [DATA_W-1:0]    readValue;

    assign mode     = {ctrlB_ff[CTRLB_WGM_LSB +: 2], ctrlA_ff[CTRLA_WGM_LSB +: 2]};
    assign clkSel   = ctrlB_ff[CTRLB_CS_LSB +: 3];
    assign pwmMode  = isPwm(mode);
    assign top      = topOf(mode, cmpA_ff, capture_ff);
    assign atTop    = (count_ff == top);
    assign capIsTop = (mode == MODE_CTC_CAP) || (mode == MODE_FAST_CAP);
    assign wrCntL   = regWr && (regAddr == REG_CNT_L);
    assign wrCapL   = regWr && (regAddr == REG_CAP_L);

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    tsa_edge_filter #(.SAMPLES(NOISE_SAMPLES)) u_extPin
    (
        .mclk      (mclk),
        .rstn      (rstn),
        .pinIn     (externalCountPin),
        .filterOn  (1'b0),
        .risingSel (clkSel == CS_EXT_RISE),
        .edgeEvt   (extEdge)
    );

    // source mux sits ahead of the synchroniser so both share one filter
    tsa_edge_filter #(.SAMPLES(NOISE_SAMPLES)) u_capPin
    (
        .mclk      (mclk),
        .rstn      (rstn),
        .pinIn     (ctrlB_ff[CTRLB_SRC_BIT] ? comparatorOutput : capturePin),
        .filterOn  (ctrlB_ff[CTRLB_NOISE_BIT]),
        .risingSel (ctrlB_ff[CTRLB_EDGE_BIT]),
        .edgeEvt   (capEdge)
    );

    // ------------------------------------------------------------
    // prescaler and tick select
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            pre_ff <= '0;
        else
            pre_ff <= pre_ff + 10'h001;
    end

    always_comb
    begin
        unique case (clkSel)
            CS_STOP:                  tick = 1'b0;
            CS_DIV1:                  tick = 1'b1;
            CS_DIV8:                  tick = (pre_ff & PRE_MASK8) == PRE_MASK8;
            CS_DIV64:                 tick = (pre_ff & PRE_MASK64) == PRE_MASK64;
            CS_DIV256:                tick = (pre_ff & PRE_MASK256) == PRE_MASK256;
            CS_DIV1024:               tick = (pre_ff & PRE_MASK1024) == PRE_MASK1024;
            CS_EXT_FALL, CS_EXT_RISE: tick = extEdge;
        endcase
        // power-off freezes the timer; software must clear it first
        if (powerOff_ff)
            tick = 1'b0;
    end

    // ------------------------------------------------------------
    // events
    // ------------------------------------------------------------
    // a count write suppresses the match on the following tick
    assign matchA  = tick && !wrCntL && !blockMatch_ff && (count_ff == cmpA_ff);
    assign matchB  = tick && !wrCntL && !blockMatch_ff && (count_ff == cmpB_ff);
    assign wrapEvt = tick && !wrCntL && atTop;
    assign capEvt  = capEdge && !powerOff_ff && !capIsTop && !wrCapL;

    assign flagSet = {capEvt, matchB, matchA, wrapEvt};
    assign flagClr = (regWr && (regAddr == REG_FLAG)) ? regWdata[NUM_FLAGS-1:0] : RST_FLAGS;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            blockMatch_ff <= 1'b0;
        else if (wrCntL)
            blockMatch_ff <= 1'b1;
        else if (tick)
            blockMatch_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            count_ff <= RST_WORD;
        else if (wrCntL)
            count_ff <= {temp_ff, regWdata};
        else if (tick)
            count_ff <= atTop ? CNT_BOTTOM : count_ff + 16'h0001;
    end

    // ------------------------------------------------------------
    // compare registers, double buffered
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmpABuf_ff <= RST_WORD;
            cmpBBuf_ff <= RST_WORD;
        end
        else
        begin
            if (regWr && (regAddr == REG_CMPA_L))
                cmpABuf_ff <= {temp_ff, regWdata};
            if (regWr && (regAddr == REG_CMPB_L))
                cmpBBuf_ff <= {temp_ff, regWdata};
        end
    end

    // pwm modes take the new value only at the wrap, so a period is never cut short
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmpA_ff <= RST_WORD;
            cmpB_ff <= RST_WORD;
        end
        else if (!pwmMode || wrapEvt)
        begin
            cmpA_ff <= cmpABuf_ff;
            cmpB_ff <= cmpBBuf_ff;
        end
    end

    // ------------------------------------------------------------
    // capture register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            capture_ff <= RST_WORD;
        else if (wrCapL)
            capture_ff <= {temp_ff, regWdata};
        else if (capEvt)
            capture_ff <= count_ff;
    end

    // ------------------------------------------------------------
    // shared high-byte latch
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            temp_ff <= RST_BYTE;
        else if (regWr && (regAddr == REG_CNT_H || regAddr == REG_CMPA_H ||
                           regAddr == REG_CMPB_H || regAddr == REG_CAP_H))
            temp_ff <= regWdata;
        else if (regRd && regAddr == REG_CNT_L)
            temp_ff <= count_ff[CNT_W-1:DATA_W];
        else if (regRd && regAddr == REG_CAP_L)
            temp_ff <= capture_ff[CNT_W-1:DATA_W];
    end

    // ------------------------------------------------------------
    // control, mask, power and flags
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrlA_ff    <= RST_BYTE;
            ctrlB_ff    <= RST_BYTE;
            mask_ff     <= RST_FLAGS;
            powerOff_ff <= RST_POWER;
        end
        else if (regWr)
        begin
            if (regAddr == REG_CTRL_A)
                ctrlA_ff <= regWdata;
            if (regAddr == REG_CTRL_B)
                ctrlB_ff <= regWdata;
            if (regAddr == REG_MASK)
                mask_ff <= regWdata[NUM_FLAGS-1:0];
            if (regAddr == REG_POWER)
                powerOff_ff <= regWdata[POWER_OFF_BIT];
        end
    end

    // write-one clears; an event in the same cycle wins
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            flags_ff <= RST_FLAGS;
        else
            flags_ff <= (flags_ff & ~flagClr) | flagSet;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            overflowReq <= 1'b0;
            compareAReq <= 1'b0;
            compareBReq <= 1'b0;
            captureReq  <= 1'b0;
        end
        else
        begin
            overflowReq <= flags_ff[FLAG_OVF_BIT] & mask_ff[FLAG_OVF_BIT];
            compareAReq <= flags_ff[FLAG_CMPA_BIT] & mask_ff[FLAG_CMPA_BIT];
            compareBReq <= flags_ff[FLAG_CMPB_BIT] & mask_ff[FLAG_CMPB_BIT];
            captureReq  <= flags_ff[FLAG_CAP_BIT] & mask_ff[FLAG_CAP_BIT];
        end
    end

    // ------------------------------------------------------------
    // waveform outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            waveOutA <= 1'b0;
            waveOutB <= 1'b0;
        end
        else
        begin
            // compare A is the ceiling here, so channel A carries no pwm
            waveOutA <= waveNext(waveOutA, ctrlA_ff[CTRLA_ENA_BIT] && mode != MODE_FAST_A,
                                 pwmMode, wrapEvt, matchA);
            waveOutB <= waveNext(waveOutB, ctrlA_ff[CTRLA_ENB_BIT], pwmMode, wrapEvt, matchB);
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (regAddr)
            REG_CTRL_A: readValue = ctrlA_ff;
            REG_CTRL_B: readValue = ctrlB_ff;
            REG_CNT_L:  readValue = count_ff[DATA_W-1:0];
            REG_CNT_H:  readValue = temp_ff;
            REG_CMPA_L: readValue = cmpABuf_ff[DATA_W-1:0];
            REG_CMPA_H: readValue = cmpABuf_ff[CNT_W-1:DATA_W];
            REG_CMPB_L: readValue = cmpBBuf_ff[DATA_W-1:0];
            REG_CMPB_H: readValue = cmpBBuf_ff[CNT_W-1:DATA_W];
            REG_CAP_L:  readValue = capture_ff[DATA_W-1:0];
            REG_CAP_H:  readValue = temp_ff;
            REG_FLAG:   readValue = {4'h0, flags_ff};
            REG_MASK:   readValue = {4'h0, mask_ff};
            REG_POWER:  readValue = {7'h00, powerOff_ff};
            default:    readValue = RST_BYTE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            regRdata <= RST_BYTE;
        else
            regRdata <= regRd ? readValue : RST_BYTE;
    end

endmodule : tsa_timer

`default_nettype wire

// >>> test/tsa_timer_checker.sv
// assertions on the timer register port and on request masking
`timescale 1ns/1ps
`default_nettype none
module tsa_timer_checker
(
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic       overflowReq,
    input wire logic       compareAReq,
    input wire logic       compareBReq,
    input wire logic       captureReq,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata
);
    logic [3:0] mask_ff;
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn) mask_ff <= 4'h0;
        else if (regWr && regAddr == 4'hB) mask_ff <= regWdata[3:0];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_idle; !$past(regRd) |-> regRdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    property p_unmap; regRd && regAddr > 4'hC |=> regRdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_latch; regWr && regAddr == 4'h3 ##1 regRd && regAddr == 4'h3 |=> regRdata == $past(regWdata, 2);
    endproperty
    a_latch: assert property (p_latch) else $error("high read not latch");
    property p_pair; regWr && regAddr == 4'h5 ##1 regWr && regAddr == 4'h4 ##1 regRd && regAddr == 4'h4
        |=> regRdata == $past(regWdata, 2); endproperty
    a_pair: assert property (p_pair) else $error("low write lost");
    property p_bypass; regWr && regAddr == 4'h3 ##1 regRd && regAddr == 4'h4 ##2 regRd && regAddr == 4'h3
        |=> regRdata == $past(regWdata, 4); endproperty
    a_bypass: assert property (p_bypass) else $error("compare read touched latch");
    property p_mask; regWr && regAddr == 4'hB ##1 regRd && regAddr == 4'hB
        |=> regRdata == ($past(regWdata, 2) & 8'h0F); endproperty
    a_mask: assert property (p_mask) else $error("mask readback wrong");
    property p_flag; regRd && regAddr == 4'hA |=> regRdata[7:4] == 4'h0; endproperty
    a_flag: assert property (p_flag) else $error("flag upper bits set");
    property p_req; ({captureReq, compareBReq, compareAReq, overflowReq} & ~$past(mask_ff)) == 4'h0; endproperty
    a_req: assert property (p_req) else $error("request not masked");
    c_ovf: cover property (overflowReq);
    c_cmp: cover property (compareAReq);
    c_cap: cover property (captureReq);
endmodule : tsa_timer_checker
bind tsa_timer tsa_timer_checker u_tsa_timer_checker (.mclk, .rstn, .regWr, .regRd, .overflowReq,
    .compareAReq, .compareBReq, .captureReq, .regAddr, .regWdata, .regRdata);
`default_nettype wire

// >>> test/tsa_cpu.sv
// byte-bus master standing in for the processor core
`timescale 1ns/1ps
`default_nettype none
module tsa_cpu
(
    input  wire logic       mclk,
    output var  logic [3:0] regAddr,
    output var  logic [7:0] regWdata,
    output var  logic       regWr,
    output var  logic       regRd,
    input  wire logic [7:0] regRdata
);
    initial {regAddr, regWdata, regWr, regRd} = 14'h0;
    // strobe held up so writes may run back to back
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        regRd <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        regAddr <= a;
        regRd <= 1'b1;
        regWr <= 1'b0;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 v = regRdata;
        @(posedge mclk);
    endtask : rd
    task automatic idle(input int n);
        regWr <= 1'b0;
        regRd <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask : idle
endmodule : tsa_cpu
`default_nettype wire

// >>> test/sixteen_bit_timer_access_test.sv
// self-checking bench for the sixteen-bit timer
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_access_test;
    logic       mclk = 1'b0, rstn = 1'b0, extPin = 1'b0, capPin = 1'b0, cmpOut = 1'b0, regWr, regRd, waveA, waveB;
    logic [3:0] regAddr, req;
    logic [7:0] regWdata, regRdata, d;
    int         fails = 0, checks_done = 0, cyc = 0;
    always #5 mclk = ~mclk;
    tsa_cpu u_tsa_cpu (.mclk, .regAddr, .regWdata, .regWr, .regRd, .regRdata);
    tsa_timer u_tsa_timer (.mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .externalCountPin(extPin), .capturePin(capPin), .comparatorOutput(cmpOut), .waveOutA(waveA),
        .waveOutB(waveB), .overflowReq(req[0]), .compareAReq(req[1]), .compareBReq(req[2]), .captureReq(req[3]));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic w(input logic [3:0] a, input logic [7:0] v); u_tsa_cpu.wr(a, v); endtask : w
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        u_tsa_cpu.rd(a, d);
        chk($sformatf("reg %h", a), d, e);
    endtask : rc
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    // hang guard, sequence needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            complete_run();
        end
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        w(4'h3, 8'h01);
        w(4'h2, 8'hFF);
        rc(4'h2, 8'hFF);
        rc(4'h3, 8'h01);
        w(4'h5, 8'h00);
        w(4'h4, 8'h02);
        rc(4'h4, 8'h02);
        w(4'h3, 8'hAB);
        rc(4'h4, 8'h02);
        rc(4'h3, 8'hAB);
        w(4'h3, 8'h5A);
        rc(4'h3, 8'h5A);
        w(4'h9, 8'h77);
        w(4'h8, 8'h66);
        rc(4'h8, 8'h66);
        rc(4'h9, 8'h77);
        rc(4'hD, 8'h00);
        w(4'h7, 8'h00);
        w(4'h6, 8'h05);
        w(4'h3, 8'h00);
        w(4'h2, 8'h00);
        w(4'hB, 8'h0F);
        rc(4'hB, 8'h0F);
        w(4'h0, 8'hA0);
        w(4'h1, 8'h01);
        u_tsa_cpu.idle(12);
        w(4'h1, 8'h00);
        rc(4'hA, 8'h06);
        chk("requests", {4'h0, req}, 8'h06);
        chk("waves", {6'h00, waveA, waveB}, 8'h03);
        w(4'hA, 8'hFF);
        rc(4'hA, 8'h00);
        w(4'h0, 8'h01);
        w(4'h3, 8'h00);
        w(4'h2, 8'hFD);
        w(4'h1, 8'h01);
        u_tsa_cpu.idle(6);
        w(4'h1, 8'h00);
        u_tsa_cpu.rd(4'hA, d);
        chk("overflow", d & 8'h01, 8'h01);
        rc(4'h2, 8'h04);
        rc(4'h3, 8'h00);
        w(4'h0, 8'h00);
        w(4'h3, 8'h00);
        w(4'h2, 8'h00);
        w(4'h1, 8'h07);
        repeat (3)
        begin
            extPin <= 1'b1;
            u_tsa_cpu.idle(6);
            extPin <= 1'b0;
            u_tsa_cpu.idle(6);
        end
        rc(4'h2, 8'h03);
        w(4'h3, 8'h12);
        w(4'h2, 8'h34);
        w(4'h1, 8'h40);
        w(4'hA, 8'hFF);
        u_tsa_cpu.idle(2);
        capPin <= 1'b1;
        u_tsa_cpu.idle(12);
        rc(4'h8, 8'h34);
        rc(4'h9, 8'h12);
        rc(4'hA, 8'h08);
        w(4'h1, 8'h60);
        w(4'hA, 8'hFF);
        u_tsa_cpu.idle(6);
        cmpOut <= 1'b1;
        u_tsa_cpu.idle(6);
        rc(4'hA, 8'h08);
        w(4'hC, 8'h01);
        w(4'h1, 8'h01);
        u_tsa_cpu.idle(6);
        rc(4'h2, 8'h34);
        complete_run();
    end
endmodule : sixteen_bit_timer_access_test
`default_nettype wire
